// ==== hw/firp_consts.svh ====
// constants for the fast infrared pin polarity and status block
`ifndef FIRP_CONSTS_SVH
`define FIRP_CONSTS_SVH
// register byte addresses
`define FIRP_CTRL_ADDR 8'h00
`define FIRP_STATA_ADDR 8'h04
`define FIRP_STATB_ADDR 8'h08
`define FIRP_IMASK_ADDR 8'h0c
// control register fields
`define FIRP_SPEED_BIT 3
`define FIRP_RXEN_BIT 1
`define FIRP_LOOP_BIT 0
`define FIRP_TXINV_BIT 18
`define FIRP_RXINV_BIT 19
`define FIRP_CTRL_RST 32'h0000_0000
// status a fields
`define FIRP_ABORT_BIT 2
`define FIRP_FRAME_BIT 1
`define FIRP_EIF_BIT 0
// status b fields
`define FIRP_LOCK_BIT 0
`define FIRP_CRC_BIT 1
`define FIRP_OVF_BIT 2
// abort when this many empty chips follow each other
`define FIRP_EMPTY_CHIPS 2
`endif

// ==== hw/firp_pkg.sv ====
// types for the fast infrared pin polarity and status block
`default_nettype none
package firp_pkg;
    typedef enum logic [1:0] {
        FIRP_HUNT = 2'b01,
        FIRP_LOCK = 2'b10
    } firp_rx_state_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [2:0] stat_a;
        logic [2:0] stat_b_sticky;
        logic [2:0] imask;
        logic [31:0] rdata;
        logic [1:0] empty_cnt;
        firp_rx_state_t rx_state;
        logic eof_mark;
    } firp_state_t;
endpackage : firp_pkg
`default_nettype wire

// ==== hw/firp_core.sv ====
// pin polarity control and status flags of the fast infrared port
//------------------------------------------------------------------
// Function
// - tx pin invert select 0 inverts all transmit sources, 1 passes true
// - rx pin invert select 0 inverts receive pin before use, 1 passes true
// - two empty chips or bad chip outside stop flag in frame sets abort, marks eof, interrupts if unmasked
// - locked flag reads 0 hunting or disabled, 1 locked, never interrupts
// - end or error in queue flag is read only, interrupts unmaskably
// - framing fault flag is read write and interrupts unmaskably
// - checksum fault flag is read only and never interrupts
// - receive overflow flag is read only and never interrupts
// - speed select 1 enables fast framer, 0 slow modulator with uart
//------------------------------------------------------------------
`include "firp_consts.svh"
`default_nettype none
module firp_core
    import firp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // transmit sources and pin
    input wire logic fast_tx_i,
    input wire logic uart_tx_i,
    input wire logic pin_ctrl_tx_i,
    input wire logic pin_ctrl_owns_i,
    output logic port2_transmit_pin_o,
    // receive pin and users
    input wire logic port2_receive_pin_i,
    output logic fast_rx_o,
    output logic uart_rx_o,
    output logic pin_ctrl_rx_o,
    // engine enables
    output logic fast_ir_framer_en_o,
    output logic slow_ir_en_o,
    // chip decoder events from the fast framer
    input wire logic chip_valid_i,
    input wire logic chip_empty_i,
    input wire logic chip_bad_i,
    input wire logic in_stop_flag_i,
    input wire logic in_frame_i,
    input wire logic sync_found_i,
    input wire logic queue_end_error_i,
    input wire logic framing_err_i,
    input wire logic crc_err_i,
    input wire logic overflow_i,
    output logic eof_mark_o,
    output logic irq_o
);
    // refuse an address bus too narrow to tell the four registers apart
    if (ADDR_W < 4) begin : g_addr_check
        $error("firp_core: ADDR_W too small for the register map");
    end

    firp_state_t s_q;
    firp_state_t s_d;
    logic tx_src;
    logic rx_pin;
    logic abort_ev;
    logic lock_flag;
    logic w_ctrl;
    logic w_stat_a;
    logic w_mask;

    //------------------------------------------------------------------
    // pin polarity and engine select
    //------------------------------------------------------------------
    // the transmit mux follows pin ownership, then polarity is applied once
    always_comb begin
        if (pin_ctrl_owns_i) begin
            tx_src = pin_ctrl_tx_i;
        end else if (s_q.ctrl[`FIRP_SPEED_BIT]) begin
            tx_src = fast_tx_i;
        end else begin
            tx_src = uart_tx_i;
        end
    end
    assign port2_transmit_pin_o = s_q.ctrl[`FIRP_TXINV_BIT] ? tx_src
                                                             : ~tx_src;
    assign rx_pin = s_q.ctrl[`FIRP_RXINV_BIT] ? port2_receive_pin_i
                                               : ~port2_receive_pin_i;
    assign fast_rx_o = rx_pin;
    assign uart_rx_o = rx_pin;
    assign pin_ctrl_rx_o = rx_pin;
    assign fast_ir_framer_en_o = s_q.ctrl[`FIRP_SPEED_BIT];
    assign slow_ir_en_o = ~s_q.ctrl[`FIRP_SPEED_BIT];

    //------------------------------------------------------------------
    // abort detection and lock state
    //------------------------------------------------------------------
    // empty run counter saturates so long gaps never wrap back to zero
    assign abort_ev = in_frame_i && chip_valid_i &&
        ((chip_empty_i && (s_q.empty_cnt == 2'(`FIRP_EMPTY_CHIPS - 1)))
         || (chip_bad_i && !in_stop_flag_i));
    assign lock_flag = (s_q.rx_state == FIRP_LOCK) &&
                       s_q.ctrl[`FIRP_RXEN_BIT];
    assign w_ctrl = wr_i && (addr_i == ADDR_W'(`FIRP_CTRL_ADDR));
    assign w_stat_a = wr_i && (addr_i == ADDR_W'(`FIRP_STATA_ADDR));
    assign w_mask = wr_i && (addr_i == ADDR_W'(`FIRP_IMASK_ADDR));

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.eof_mark = abort_ev;
        if (w_ctrl) begin
            s_d.ctrl = wdata_i;
        end
        if (w_mask) begin
            s_d.imask = wdata_i[2:0];
        end
        // empty chip run
        if (!in_frame_i) begin
            s_d.empty_cnt = 2'h0;
        end else if (chip_valid_i) begin
            if (!chip_empty_i) begin
                s_d.empty_cnt = 2'h0;
            end else if (s_q.empty_cnt != 2'h3) begin
                s_d.empty_cnt = s_q.empty_cnt + 2'h1;
            end
        end
        // hunt and lock
        unique case (s_q.rx_state)
            FIRP_HUNT: begin
                if (sync_found_i && s_q.ctrl[`FIRP_RXEN_BIT]) begin
                    s_d.rx_state = FIRP_LOCK;
                end
            end
            FIRP_LOCK: begin
                if (abort_ev || !in_frame_i && !sync_found_i) begin
                    s_d.rx_state = FIRP_HUNT;
                end
            end
            default: s_d.rx_state = FIRP_HUNT;
        endcase
        if (!s_d.ctrl[`FIRP_RXEN_BIT]) begin
            s_d.rx_state = FIRP_HUNT;
        end
        // write one clears abort and framing; set beats clear
        if (w_stat_a) begin
            s_d.stat_a[`FIRP_ABORT_BIT] = s_q.stat_a[`FIRP_ABORT_BIT] &
                ~wdata_i[`FIRP_ABORT_BIT];
            s_d.stat_a[`FIRP_FRAME_BIT] = s_q.stat_a[`FIRP_FRAME_BIT] &
                ~wdata_i[`FIRP_FRAME_BIT];
        end
        if (abort_ev) begin
            s_d.stat_a[`FIRP_ABORT_BIT] = 1'b1;
        end
        if (framing_err_i) begin
            s_d.stat_a[`FIRP_FRAME_BIT] = 1'b1;
        end
        // end/error in queue follows the queue, software cannot write it
        s_d.stat_a[`FIRP_EIF_BIT] = queue_end_error_i;
        s_d.stat_b_sticky[`FIRP_LOCK_BIT] = 1'b0;
        s_d.stat_b_sticky[`FIRP_CRC_BIT] = crc_err_i;
        s_d.stat_b_sticky[`FIRP_OVF_BIT] = overflow_i;
        // read data, one cycle after the strobe
        s_d.rdata = 32'h0000_0000;
        if (rd_i) begin
            if (addr_i == ADDR_W'(`FIRP_CTRL_ADDR)) begin
                s_d.rdata = s_q.ctrl;
            end else if (addr_i == ADDR_W'(`FIRP_STATA_ADDR)) begin
                s_d.rdata = {29'h0, s_q.stat_a};
            end else if (addr_i == ADDR_W'(`FIRP_STATB_ADDR)) begin
                s_d.rdata = {29'h0, s_q.stat_b_sticky[2:1], lock_flag};
            end else if (addr_i == ADDR_W'(`FIRP_IMASK_ADDR)) begin
                s_d.rdata = {29'h0, s_q.imask};
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '{ctrl: `FIRP_CTRL_RST, stat_a: 3'h0,
                     stat_b_sticky: 3'h0, imask: 3'h0, rdata: 32'h0,
                     empty_cnt: 2'h0, rx_state: FIRP_HUNT, eof_mark: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    // abort is maskable; eif and framing are not; lock, crc, overflow never
    assign irq_o = s_q.stat_a[`FIRP_EIF_BIT] |
                   s_q.stat_a[`FIRP_FRAME_BIT] |
                   (s_q.stat_a[`FIRP_ABORT_BIT] &
                    s_q.imask[`FIRP_ABORT_BIT]);
    assign rdata_o = s_q.rdata;
    assign eof_mark_o = s_q.eof_mark;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    // an abort decoded in one cycle is flagged and marked in the next
    sequence abort_seen;
        abort_ev;
    endsequence

    sequence abort_flagged;
        eof_mark_o && s_q.stat_a[`FIRP_ABORT_BIT];
    endsequence

    // a write of one clears abort only when no new abort lands with it
    sequence abort_cleared;
        s_q.stat_a[`FIRP_ABORT_BIT] && w_stat_a &&
            wdata_i[`FIRP_ABORT_BIT] && !abort_ev;
    endsequence

    // a sync hit with receive enabled and no control write in flight
    sequence lock_request;
        (s_q.rx_state == FIRP_HUNT) && sync_found_i &&
            s_q.ctrl[`FIRP_RXEN_BIT] && !w_ctrl;
    endsequence

    // events that may only reach status b, never the interrupt
    sequence quiet_events;
        (crc_err_i || overflow_i) && (s_q.stat_a == 3'h0) &&
            !abort_ev && !framing_err_i && !queue_end_error_i;
    endsequence

    // pin polarity and source choice
    a_tx_polarity: assert property (
        port2_transmit_pin_o == (tx_src ^ ~s_q.ctrl[`FIRP_TXINV_BIT]))
        else $error("tx pin polarity wrong");
    a_tx_owner: assert property (
        pin_ctrl_owns_i |-> (tx_src == pin_ctrl_tx_i))
        else $error("pin controller lost the tx pin");
    a_rx_polarity: assert property (
        fast_rx_o == (port2_receive_pin_i ^ ~s_q.ctrl[`FIRP_RXINV_BIT]))
        else $error("rx pin polarity wrong");
    a_rx_fanout: assert property (
        (uart_rx_o == fast_rx_o) && (pin_ctrl_rx_o == fast_rx_o))
        else $error("rx users see different data");

    // abort flag, end of frame mark and its interrupt
    a_abort_marks: assert property (
        abort_seen |=> abort_flagged)
        else $error("abort not flagged");
    a_eof_pulse: assert property (
        !abort_ev |=> !eof_mark_o)
        else $error("eof mark without abort");
    a_abort_clear: assert property (
        abort_cleared |=> !s_q.stat_a[`FIRP_ABORT_BIT])
        else $error("abort flag not cleared");
    a_abort_masked: assert property (
        (s_q.stat_a == 3'h4) && !s_q.imask[`FIRP_ABORT_BIT] |-> !irq_o)
        else $error("masked abort interrupts");

    // lock flag
    a_lock_disabled: assert property (
        !s_q.ctrl[`FIRP_RXEN_BIT] |-> !lock_flag)
        else $error("locked while disabled");
    a_lock_gain: assert property (
        lock_request |=> lock_flag)
        else $error("sync did not lock");
    a_lock_no_irq: assert property (
        lock_flag && (s_q.stat_a == 3'h0) |-> !irq_o)
        else $error("lock raised an interrupt");

    // unmaskable flags
    a_eif_irq: assert property (
        queue_end_error_i |=> irq_o)
        else $error("eif irq missing");
    a_eif_live: assert property (
        !queue_end_error_i |=> !s_q.stat_a[`FIRP_EIF_BIT])
        else $error("eif set without a queue event");
    a_frame_irq: assert property (
        framing_err_i |=> irq_o)
        else $error("framing irq missing");

    // flags that never interrupt
    a_crc_quiet: assert property (
        (s_q.stat_a == 3'h0) |-> !irq_o)
        else $error("irq without cause");
    a_crc_copy: assert property (
        crc_err_i |=> s_q.stat_b_sticky[`FIRP_CRC_BIT])
        else $error("checksum fault not shown");
    a_ovf_copy: assert property (
        overflow_i |=> s_q.stat_b_sticky[`FIRP_OVF_BIT])
        else $error("overflow not shown");
    a_quiet_events: assert property (
        quiet_events |=> !irq_o)
        else $error("checksum or overflow interrupts");

    // engine select and hold until cleared
    a_speed_sel: assert property (
        fast_ir_framer_en_o != slow_ir_en_o)
        else $error("engine select clash");
    a_speed_fast: assert property (
        s_q.ctrl[`FIRP_SPEED_BIT] |-> fast_ir_framer_en_o)
        else $error("fast engine not enabled");
    a_frame_hold: assert property (
        s_q.stat_a[`FIRP_FRAME_BIT] && !w_stat_a
        |=> s_q.stat_a[`FIRP_FRAME_BIT])
        else $error("framing flag dropped");
    a_abort_hold: assert property (
        s_q.stat_a[`FIRP_ABORT_BIT] && !w_stat_a
        |=> s_q.stat_a[`FIRP_ABORT_BIT])
        else $error("abort flag dropped");
endmodule : firp_core
`default_nettype wire

// ==== dv/firp_ir_xcvr_model.sv ====
// behavioural infrared transceiver sitting on the port2 pins
`default_nettype none
module firp_ir_xcvr_model (
    input wire logic tx_pin_i,
    input wire logic light_in_i,
    output logic light_out_o,
    output logic rx_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // emitter lights while the pin is high; no filtering, so any
    // glitch on the pin reaches the far side unchanged
    assign light_out_o = tx_pin_i;
    assign rx_pin_o = light_in_i;
endmodule : firp_ir_xcvr_model
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the fast infrared polarity and status block
`include "firp_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 0, reset_n_i = 0, wr = 0, rd = 0, pown = 0;
    logic [2:0] srcs = 3'h0;
    logic exp_tx;
    logic light = 0, rx_pin_invert_select, lto, frx, urx, prx, fen, sen, tx_pin_invert_select, eof, irq;
    logic cv = 0, ce = 0, cb = 0, stp = 0, infr = 0, sync = 0;
    logic qee = 0, fe = 0, crc = 0, ovf = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, x = 32'h51;
    int n_mismatch = 0, checks = 0, m_ab = 0, m_fr = 0, m_msk = 0, pe = 0;
    //--------------------------------------------------------------
    // design, transceiver and clock
    //--------------------------------------------------------------
    firp_core firp_core_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .fast_tx_i(srcs[0]), .uart_tx_i(srcs[1]),
        .pin_ctrl_tx_i(srcs[2]), .pin_ctrl_owns_i(pown),
        .port2_transmit_pin_o(tx_pin_invert_select), .port2_receive_pin_i(rx_pin_invert_select),
        .fast_rx_o(frx), .uart_rx_o(urx), .pin_ctrl_rx_o(prx),
        .fast_ir_framer_en_o(fen), .slow_ir_en_o(sen), .chip_valid_i(cv),
        .chip_empty_i(ce), .chip_bad_i(cb), .in_stop_flag_i(stp),
        .in_frame_i(infr), .sync_found_i(sync), .queue_end_error_i(qee),
        .framing_err_i(fe), .crc_err_i(crc), .overflow_i(ovf),
        .eof_mark_o(eof), .irq_o(irq));
    firp_ir_xcvr_model firp_ir_xcvr_model_i (.tx_pin_i(tx_pin_invert_select),
        .light_in_i(light), .light_out_o(lto), .rx_pin_o(rx_pin_invert_select));
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        stop_test();
    end
    //--------------------------------------------------------------
    // tasks
    //--------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    function automatic logic [31:0] xs();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(negedge clock_i);
        chk(rdata, e);
    endtask : rd_reg
    // irq model: abort is the only maskable source
    task automatic chk_irq();
        @(negedge clock_i);
        chk(irq, 32'(qee | m_fr | (m_ab & m_msk[2])));
    endtask : chk_irq
    // one decoded chip; model predicts abort from consecutive empties
    task automatic chip(input int e, input int b);
        int ab;
        // predict after the edge so levels driven before it are already seen
        @(posedge clock_i);
        ab = infr && ((e && pe) || (b && !stp));
        pe = e;
        cv <= 1'b1;
        ce <= e[0];
        cb <= b[0];
        @(posedge clock_i);
        cv <= 1'b0;
        @(negedge clock_i);
        chk(eof, ab);
        if (ab) m_ab = 1;
    endtask : chip
    //--------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock_i);
        reset_n_i <= 1'b1;
        rd_reg(`FIRP_CTRL_ADDR, 32'h0);
        chk({fen, sen}, 32'h1);
        rd_reg(8'h10, 32'h0);
        wr_reg(8'h10, 32'hffff_ffff);
        wr_reg(`FIRP_STATB_ADDR, 32'hffff_ffff);
        rd_reg(`FIRP_STATB_ADDR, 32'h0);
        // all polarity settings with random pin traffic
        for (int p = 0; p < 4; p++) begin
            wr_reg(`FIRP_CTRL_ADDR, (p << 18) | ((p & 1) << 3));
            @(negedge clock_i);
            chk({fen, sen}, 32'((p & 1) ? 2 : 1));
            for (int i = 0; i < 6; i++) begin
                void'(xs());
                @(posedge clock_i);
                srcs <= x[5:3];
                light <= x[1];
                pown <= x[2];
                @(negedge clock_i);
                // pin controller owns the pin, else speed picks the engine
                exp_tx = pown ? srcs[2] : (p[0] ? srcs[0] : srcs[1]);
                chk(lto, 32'(exp_tx ^ !p[0]));
                chk({frx, urx, prx}, {3{x[1] ^ !p[1]}});
            end
        end
        // lock follows sync and drops when receive is disabled
        @(posedge clock_i);
        infr <= 1'b1;
        wr_reg(`FIRP_CTRL_ADDR, 32'h000c_000a);
        sync <= 1'b1;
        rd_reg(`FIRP_STATB_ADDR, 32'h1);
        chk_irq();
        wr_reg(`FIRP_CTRL_ADDR, 32'h000c_0008);
        rd_reg(`FIRP_STATB_ADDR, 32'h0);
        // checksum and overflow flags never interrupt
        @(posedge clock_i);
        sync <= 1'b0;
        crc <= 1'b1;
        ovf <= 1'b1;
        rd_reg(`FIRP_STATB_ADDR, 32'h6);
        chk_irq();
        // end or error flag: live, read only, not maskable
        @(posedge clock_i);
        crc <= 1'b0;
        ovf <= 1'b0;
        qee <= 1'b1;
        wr_reg(`FIRP_STATA_ADDR, 32'h1);
        rd_reg(`FIRP_STATA_ADDR, 32'h1);
        chk_irq();
        // framing fault is sticky until written with a one
        @(posedge clock_i);
        qee <= 1'b0;
        fe <= 1'b1;
        @(posedge clock_i);
        fe <= 1'b0;
        m_fr = 1;
        repeat (3) chk_irq();
        rd_reg(`FIRP_STATA_ADDR, 32'h2);
        wr_reg(`FIRP_STATA_ADDR, 32'h2);
        m_fr = 0;
        chk_irq();
        // empty, good, empty must not abort; then two empties must
        chip(1, 0);
        chip(0, 0);
        chip(1, 0);
        rd_reg(`FIRP_STATA_ADDR, 32'h0);
        chip(1, 0);
        rd_reg(`FIRP_STATA_ADDR, 32'h4);
        chk_irq();
        wr_reg(`FIRP_IMASK_ADDR, 32'h4);
        m_msk = 4;
        chk_irq();
        wr_reg(`FIRP_STATA_ADDR, 32'h4);
        m_ab = 0;
        chk_irq();
        // bad chip inside the stop flag is legal, outside it aborts
        pe = 0;
        @(posedge clock_i);
        stp <= 1'b1;
        chip(0, 1);
        @(posedge clock_i);
        stp <= 1'b0;
        chip(0, 1);
        rd_reg(`FIRP_STATA_ADDR, 32'h4);
        chk_irq();
        stop_test();
    end
endmodule : tb
`default_nettype wire
